// [shared/wtt_pkg.sv]
package wtt_pkg;
    // ****************************************
    // Register fields of watch_mode_control
    // ****************************************
    localparam int          WMC_MODE_BIT     = 0;
    localparam int          WMC_PRESC_RUN    = 1;
    localparam int          WMC_COUNTER_RUN  = 2;
    localparam int          WMC_FLAG_PERIOD  = 3;
    localparam int          WMC_IVL_LSB      = 4;
    localparam int          WMC_IVL_W        = 3;
    localparam logic [7:0]  WMC_RESET        = 8'h00;
    // ****************************************
    // Field of shared_clock_select
    // ****************************************
    localparam int          SCS_SRC_BIT      = 4;
    localparam logic [7:0]  SCS_RESET        = 8'h00;
    // ****************************************
    // Divider and counter sizes
    // ****************************************
    localparam int          MAIN_DIV_LOG2    = 8;
    localparam int          PRESC_W          = 9;
    localparam int          IVL_TAP_BASE     = 4;
    localparam logic [2:0]  IVL_CODE_MAX     = 3'h5;
    localparam int          CNT_W            = 5;
    localparam logic [4:0]  CNT_FULL         = 5'h1f;
    localparam logic [4:0]  CNT_HALF         = 5'h0f;
    // ****************************************
    // Standby release state machine
    // ****************************************
    typedef enum logic [1:0] {
        WTT_IDLE = 2'b01,
        WTT_HOLD = 2'b10
    } wtt_wake_e;
endpackage : wtt_pkg

// [logic/wtt_watch_timer.sv]
`timescale 1ns/1ps
module wtt_watch_timer
    import wtt_pkg::*;
(
    input  wire logic        i_clock,
    input  wire logic        i_rst_n,
    input  wire logic        i_main_tick,
    input  wire logic        i_sub_tick,
    input  wire logic        i_wmc_byte_we,
    input  wire logic        i_wmc_bit_we,
    input  wire logic [2:0]  i_wmc_bit_sel,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_scs_we,
    input  wire logic        i_watch_flag_clr,
    input  wire logic        i_ivl_flag_clr,
    input  wire logic        i_standby,
    output logic      [7:0]  o_watch_mode_control,
    output logic      [7:0]  o_shared_clock_select,
    output logic             o_watch_tick_flag,
    output logic             o_interval_tick_irq,
    output logic             o_standby_release,
    output logic      [4:0]  o_counter_value
);
    // ****************************************
    // Registers
    // ****************************************
    logic [7:0]          wmc;
    logic [7:0]          scs;
    logic [MAIN_DIV_LOG2-1:0] main_div;
    logic [PRESC_W-1:0]  presc;
    logic [CNT_W-1:0]    cnt;
    logic                watch_flag;
    logic                ivl_flag;
    wtt_wake_e           wake_state;

    // ****************************************
    // Write decode
    // ****************************************
    logic [7:0] bit_mask;
    logic [7:0] bit_merge;
    logic [7:0] next_wmc;
    logic [7:0] next_scs;
    assign bit_mask  = 8'h01 << i_wmc_bit_sel;
    assign bit_merge = (wmc & ~bit_mask) | (i_wdata & bit_mask);
    // Byte write wins so a stray bit strobe cannot corrupt it
    assign next_wmc  = i_wmc_byte_we ? i_wdata :
                       (i_wmc_bit_we ? bit_merge : wmc);
    // Clock select takes whole bytes only
    assign next_scs  = i_scs_we ? i_wdata : scs;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wmc <= WMC_RESET;
        end else begin
            wmc <= next_wmc;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            scs <= SCS_RESET;
        end else begin
            scs <= next_scs;
        end
    end

    // ****************************************
    // Watch clock source
    // ****************************************
    logic main_div_wrap;
    logic watch_tick;
    assign main_div_wrap = i_main_tick && (&main_div);
    logic src_is_sub;
    // Subclock bypasses the divider; main clock needs 2^8 first
    assign src_is_sub = scs[SCS_SRC_BIT];
    assign watch_tick = src_is_sub ? i_sub_tick : main_div_wrap;

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            main_div <= '0;
        end else if (i_main_tick) begin
            main_div <= main_div + 1'b1;
        end
    end

    // ****************************************
    // Prescaler and interval taps
    // ****************************************
    // Tap i fires as bit i-1 and all lower bits roll over
    logic              presc_run;
    logic [PRESC_W:0]  tap;
    logic [2:0]        ivl_code;
    logic              ivl_legal;
    logic              ivl_tick;
    logic              cnt_tick;
    assign presc_run = wmc[WMC_PRESC_RUN];
    assign tap[0]    = watch_tick && presc_run;
    // Codes above the legal maximum match nothing
    function automatic logic ivl_tap_pick(input logic [2:0]       code,
                                          input logic [PRESC_W:0] taps);
        logic pick;
        pick = 1'b0;
        for (int k = 0; k <= int'(IVL_CODE_MAX); k++) begin
            if (int'(code) == k) begin
                pick = taps[IVL_TAP_BASE + k];
            end
        end
        return pick;
    endfunction : ivl_tap_pick

    genvar g;
    generate
        for (g = 0; g < PRESC_W; g++) begin : g_tap
            assign tap[g+1] = tap[g] && presc[g];
        end
    endgenerate
    assign ivl_code  = wmc[WMC_IVL_LSB +: WMC_IVL_W];
    // Banned codes simply never fire
    assign ivl_legal = ivl_code <= IVL_CODE_MAX;
    assign ivl_tick  = ivl_legal && ivl_tap_pick(ivl_code, tap);
    assign cnt_tick  = tap[PRESC_W];

    logic [PRESC_W-1:0] next_presc;
    assign next_presc = !presc_run ? '0 :
                        (watch_tick ? presc + 1'b1 : presc);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            presc <= '0;
        end else begin
            presc <= next_presc;
        end
    end

    // ****************************************
    // Five bit watch counter
    // ****************************************
    logic       cnt_run;
    logic [4:0] cnt_top;
    logic       watch_event;
    assign cnt_run = wmc[WMC_COUNTER_RUN];
    assign cnt_top = wmc[WMC_FLAG_PERIOD] ? CNT_HALF : CNT_FULL;
    function automatic logic cnt_at_top(input logic [CNT_W-1:0] value,
                                        input logic [CNT_W-1:0] top);
        logic hit;
        hit = (value & top) == top;
        return hit;
    endfunction : cnt_at_top

    logic [CNT_W-1:0] next_cnt;
    // Masking with the top lets one counter serve both periods
    assign watch_event = cnt_run && cnt_tick &&
                         cnt_at_top(cnt, cnt_top);
    assign next_cnt    = !cnt_run ? '0 :
                         (cnt_tick ? cnt + 1'b1 : cnt);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // ****************************************
    // Sticky flags, set wins over clear
    // ****************************************
    logic next_watch_flag;
    logic next_ivl_flag;
    // A tick meeting a clear is kept, so no event is lost
    assign next_watch_flag = watch_event |
                             (watch_flag & ~i_watch_flag_clr);
    assign next_ivl_flag   = ivl_tick |
                             (ivl_flag & ~i_ivl_flag_clr);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            watch_flag <= 1'b0;
            ivl_flag   <= 1'b0;
        end else begin
            watch_flag <= next_watch_flag;
            ivl_flag   <= next_ivl_flag;
        end
    end

    // ****************************************
    // Standby release
    // ****************************************
    // Release held until standby drops so the core sees it
    logic next_release;
    assign next_release = i_standby &&
                          (watch_event || wake_state == WTT_HOLD);

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wake_state <= WTT_IDLE;
        end else begin
            unique case (wake_state)
                WTT_IDLE: begin
                    if (watch_event && i_standby) begin
                        wake_state <= WTT_HOLD;
                    end
                end
                WTT_HOLD: begin
                    if (!i_standby) begin
                        wake_state <= WTT_IDLE;
                    end
                end
                default: wake_state <= WTT_IDLE;
            endcase
        end
    end

    // ****************************************
    // Control register mirror
    // ****************************************
    // Mirrors load the same next value, so they track their flops
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_watch_mode_control <= WMC_RESET;
        end else begin
            o_watch_mode_control <= next_wmc;
        end
    end

    // ****************************************
    // Clock select mirror
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_shared_clock_select <= SCS_RESET;
        end else begin
            o_shared_clock_select <= next_scs;
        end
    end

    // ****************************************
    // Watch flag output
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_watch_tick_flag <= 1'b0;
        end else begin
            o_watch_tick_flag <= next_watch_flag;
        end
    end

    // ****************************************
    // Interval request output
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_interval_tick_irq <= 1'b0;
        end else begin
            o_interval_tick_irq <= next_ivl_flag;
        end
    end

    // ****************************************
    // Standby release output
    // ****************************************
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_standby_release <= 1'b0;
        end else begin
            o_standby_release <= next_release;
        end
    end

    // ****************************************
    // Counter output
    // ****************************************
    // Shows the count a reader would see after this edge
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_counter_value <= '0;
        end else begin
            o_counter_value <= next_cnt;
        end
    end
endmodule : wtt_watch_timer

// [test/wtt_watch_timer_properties.sv]
`timescale 1ns/1ps
module wtt_watch_timer_chk (
    input wire logic       i_clock,
    input wire logic       i_rst_n,
    input wire logic       i_wmc_byte_we,
    input wire logic [7:0] i_wdata,
    input wire logic       i_scs_we,
    input wire logic       i_watch_flag_clr,
    input wire logic       i_ivl_flag_clr,
    input wire logic       i_standby,
    input wire logic [7:0] o_watch_mode_control,
    input wire logic [7:0] o_shared_clock_select,
    input wire logic       o_watch_tick_flag,
    input wire logic       o_interval_tick_irq,
    input wire logic       o_standby_release,
    input wire logic [4:0] o_counter_value
);
    // ********
    // Checks
    // ********
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    chk_wmc_byte: assert property (i_wmc_byte_we |=>
        o_watch_mode_control == $past(i_wdata)) else $error("wmc write");
    chk_scs_byte: assert property (i_scs_we |=>
        o_shared_clock_select == $past(i_wdata)) else $error("scs write");
    chk_cnt_hold: assert property (!o_watch_mode_control[2] [*4]
        |-> o_counter_value == 5'h00) else $error("counter not held");
    chk_wflag_keep: assert property (o_watch_tick_flag &&
        !i_watch_flag_clr |=> o_watch_tick_flag) else $error("wflag lost");
    chk_iflag_keep: assert property (o_interval_tick_irq &&
        !i_ivl_flag_clr |=> o_interval_tick_irq) else $error("iflag lost");
    chk_rel_hold: assert property (o_standby_release && i_standby
        |=> o_standby_release) else $error("release dropped");
    chk_cnt_step: assert property ($changed(o_counter_value) |->
        o_counter_value == $past(o_counter_value) + 5'h01 ||
        o_counter_value == 5'h00) else $error("counter jump");
    chk_ivl_refuse: assert property (!o_interval_tick_irq &&
        o_watch_mode_control[6:5] == 2'h3 |=> !o_interval_tick_irq)
        else $error("banned code ticked");
    cover property ($rose(o_watch_tick_flag));
    cover property ($rose(o_interval_tick_irq));
    cover property ($rose(o_standby_release));
endmodule : wtt_watch_timer_chk
bind wtt_watch_timer wtt_watch_timer_chk u_chk (.*);

// [test/watch_timer_with_interval_tick_tb_top.sv]
`timescale 1ns/1ps
module watch_timer_with_interval_tick_tb_top;
    logic i_clock = 0, i_rst_n = 0, i_main_tick = 0, i_sub_tick = 0;
    logic i_standby = 0, i_wmc_byte_we, i_wmc_bit_we, i_scs_we;
    logic i_watch_flag_clr, i_ivl_flag_clr, o_watch_tick_flag;
    logic o_interval_tick_irq, o_standby_release;
    logic [2:0] i_wmc_bit_sel = 0;
    logic [4:0] stb = 0, o_counter_value;
    logic [7:0] i_wdata = 0, o_watch_mode_control, r, e;
    logic [7:0] o_shared_clock_select;
    int err_count = 0, n_compared = 0, n;
    assign {i_ivl_flag_clr, i_watch_flag_clr, i_scs_we, i_wmc_bit_we,
        i_wmc_byte_we} = stb;
    wtt_watch_timer DUT (.*);
    initial forever #2 i_clock = ~i_clock;
    // ********
    // Tasks
    // ********
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic drv(input logic [4:0] s, input logic [2:0] b,
                       input logic [7:0] d);
        stb = s;
        i_wmc_bit_sel = b;
        i_wdata = d;
        @(posedge i_clock) #1;
        stb = 5'h00;
        // Let an edge pass so back-to-back calls never merge
        @(posedge i_clock) #1;
    endtask : drv
    function automatic int ivl_period(input int c);
        return c < 6 ? 1 << (4 + c) : 1025;
    endfunction : ivl_period
    // Stop first so a source change never hits a running count
    task automatic cfg(input logic [7:0] s, input logic [7:0] w);
        drv(5'h01, 3'h0, 8'h00);
        drv(5'h1c, 3'h0, s);
        drv(5'h01, 3'h0, w);
    endtask : cfg
    // Returns tick count until flag, lim + 1 if never
    task automatic run(input bit m, input bit w, input int lim);
        for (n = 1; n <= lim; n++) begin
            {i_main_tick, i_sub_tick} = {m, !m};
            @(posedge i_clock) #1;
            {i_main_tick, i_sub_tick} = 2'h0;
            @(posedge i_clock) #1;
            if ((w ? o_watch_tick_flag : o_interval_tick_irq) === 1'b1)
                break;
        end
    endtask : run
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : final_report
    initial begin
        void'($urandom(57));
        repeat (5) @(posedge i_clock);
        #1 i_rst_n = 1;
        chk(o_watch_mode_control, 8'h00);
        chk(o_shared_clock_select, 8'h00);
        repeat (6) begin
            r = 8'($urandom);
            n = $urandom_range(7);
            drv(5'h01, 3'h0, 8'h00);
            drv(5'h04, 3'h0, r);
            chk(o_shared_clock_select, r);
            drv(5'h01, 3'h0, ~r);
            e = ~r;
            e[n] = r[n];
            drv(5'h02, n[2:0], r);
            chk(o_watch_mode_control, e);
        end
        $display("test registers done");
        cfg(8'h00, 8'h06);
        run(1, 0, 5000);
        chk(n >= 3841 && n <= 4096, 1);
        $display("test main source done");
        for (int c = 0; c < 8; c++) begin
            cfg(8'h10, {1'b0, 3'(c), 4'h6});
            repeat (2) begin
                run(0, 0, 1024);
                chk(n, ivl_period(c));
                drv(5'h10, 3'h0, 8'h00);
            end
        end
        $display("test intervals done");
        cfg(8'h10, 8'h56);
        run(0, 1, 1536);
        chk(o_counter_value, 5'h03);
        drv(5'h02, 3'h2, 8'h00);
        run(0, 1, 600);
        chk(o_counter_value, 5'h00);
        drv(5'h02, 3'h2, 8'h04);
        run(0, 1, 511);
        chk(o_counter_value, 5'h01);
        $display("test counter done");
        i_standby = 1;
        cfg(8'h10, 8'h0e);
        repeat (2) begin
            run(0, 1, 20000);
            chk(n, 8192);
            drv(5'h08, 3'h0, 8'h00);
        end
        chk(o_standby_release, 1);
        chk(o_interval_tick_irq, 1);
        i_standby = 0;
        cfg(8'h10, 8'h06);
        chk(o_standby_release, 0);
        run(0, 1, 20000);
        chk(n, 16384);
        $display("test watch done");
        final_report;
    end
endmodule : watch_timer_with_interval_tick_tb_top
